// ### sys_map_defs.svh
// Address map, register layout and sizing constants of the system bus router
`ifndef SYS_MAP_DEFS_SVH
`define SYS_MAP_DEFS_SVH

// ----------------------------------------------------------------------------
// Address windows: addr[31:26] selects one 64 MB window
// ----------------------------------------------------------------------------
`define WIN_FLASH_BOOT 6'h00
`define WIN_TCM_SRAM 6'h01
`define WIN_EXT_CS0 6'h0f
`define WIN_BUF_SRAM 6'h10
`define WIN_BUF_FLASH 6'h11
`define WIN_BUF_BRIDGE0 6'h12
`define WIN_BUF_BRIDGE1 6'h13
`define WIN_DIR_SRAM 6'h14
`define WIN_DIR_FLASH 6'h15
`define WIN_DIR_BRIDGE0 6'h16
`define WIN_DIR_BRIDGE1 6'h17
`define WIN_BUF_USB 6'h18
`define WIN_BUF_EXTMEM 6'h19
`define WIN_BUF_DMA 6'h1a
`define WIN_BUF_ENET 6'h1b
`define WIN_DIR_USB 6'h1c
`define WIN_DIR_EXTMEM 6'h1d
`define WIN_DIR_DMA 6'h1e
`define WIN_DIR_ENET 6'h1f
`define BOOT_ADDR 32'h0000_0000

// ----------------------------------------------------------------------------
// Memory sizes in bytes (26-bit window offsets) and 2-bit SRAM size codes
// ----------------------------------------------------------------------------
`define SRAM_SIZE_32K 26'h000_8000
`define SRAM_SIZE_64K 26'h001_0000
`define SRAM_SIZE_96K 26'h001_8000
`define SRAM_CODE_32K 2'h0
`define SRAM_CODE_64K 2'h1
`define SRAM_CODE_96K 2'h2
`define SRAM_CODE_MAX 2'h2
`define PRI_FLASH_SIZE 26'h008_0000
`define SEC_FLASH_SIZE 26'h000_8000

// ----------------------------------------------------------------------------
// Write FIFO
// ----------------------------------------------------------------------------
`define FIFO_DEPTH 4
`define FIFO_AW 2
`define FIFO_CW 3

// ----------------------------------------------------------------------------
// Control registers (byte offsets) and fields
// ----------------------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_PRI_BASE 8'h04
`define REG_SEC_BASE 8'h08
`define REG_STATUS 8'h0c
`define CTRL_SRAM_LO 0
`define CTRL_SRAM_HI 1
`define CTRL_BUF_EN 3
`define CTRL_PRI_EN 8
`define CTRL_SEC_EN 9
`define STAT_LEVEL_LO 0
`define STAT_LEVEL_HI 2
`define STAT_FULL 4
`define STAT_EMPTY 5
`define STAT_BOOT_SEL 8
`define STAT_BUSY 9

`endif

// ### sys_map_pkg.sv
// Types shared by the system bus router and its write FIFO
package sys_map_pkg;

  typedef enum logic [3:0] {
    TGT_NONE, TGT_FLASH_PRI, TGT_FLASH_SEC, TGT_SRAM, TGT_EXT_CS0,
    TGT_BRIDGE0, TGT_BRIDGE1, TGT_USB, TGT_EXTMEM, TGT_DMA, TGT_ENET
  } target_e;

  typedef enum logic [1:0] {ST_IDLE, ST_FIFO, ST_DIRECT} bus_state_e;

  typedef struct packed {
    logic write;
    logic cpu;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bus_req_s;

  typedef struct packed {
    target_e target;
    logic write;
    logic [25:0] offset;
    logic [31:0] wdata;
  } sb_req_s;

  typedef struct packed {
    target_e target;
    logic buffered;
    logic [25:0] offset;
  } decode_s;

endpackage

// ### write_fifo.sv
// Write FIFO holding buffered system bus writes in issue order
`timescale 1ns/1ps
`include "sys_map_defs.svh"

module write_fifo (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Fill side
  input wire logic push_valid,
  input sys_map_pkg::sb_req_s push_data,
  output logic push_ready,
  // Drain side
  output logic pop_valid,
  output sys_map_pkg::sb_req_s pop_data,
  input wire logic pop_ready,
  // Fill level
  output logic [`FIFO_CW-1:0] level
);
  import sys_map_pkg::*;

  sb_req_s mem_q [`FIFO_DEPTH];
  logic [`FIFO_AW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [`FIFO_CW-1:0] count_q, count_d;
  logic do_push, do_pop;

  assign push_ready = (count_q != `FIFO_CW'(`FIFO_DEPTH));
  assign pop_valid = (count_q != '0);
  assign pop_data = mem_q[rd_ptr_q];
  assign level = count_q;

  always_comb begin
    do_push = push_valid && push_ready;
    do_pop = pop_valid && pop_ready;
    wr_ptr_d = do_push ? wr_ptr_q + 1'b1 : wr_ptr_q;
    rd_ptr_d = do_pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
    count_d = count_q;
    if (do_push && !do_pop) begin
      count_d = count_q + 1'b1;
    end else if (do_pop && !do_push) begin
      count_d = count_q - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q <= count_d;
    end
  end

  // Storage needs no reset: only entries written since reset are ever popped
  always_ff @(posedge sys_clk) begin
    if (do_push) begin
      mem_q[wr_ptr_q] <= push_data;
    end
  end

endmodule

// ### system_bus_map_write_buffer.sv
// Address decoder and write path between bus masters and system bus targets
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "sys_map_defs.svh"

// Behaviour
// RULE_01: Decode one flat 32-bit, 4 GB address space for the CPU.
// RULE_02: After reset, address zero hits offset zero of the flash memory interface.
// RULE_03: Buffering enable bit 3 is clear after reset; all writes go direct.
// RULE_04: Software must set bit 3 and use the buffered alias to buffer.
// RULE_05: Most targets answer at a buffered and a direct alias range.
// RULE_06: Buffered writes enter the write FIFO; the CPU continues at once.
// RULE_07: Buffered write into a full FIFO stalls the CPU until space frees.
// RULE_08: Direct writes go straight to the target and hold the CPU until done.
// RULE_09: Reads always go direct, never through the write FIFO.
// RULE_10: Peripheral address is bridge window base plus peripheral and location offsets.
// RULE_11: SRAM aliases at 0x0400_0000 tightly coupled, 0x4000_0000 buffered, 0x5000_0000 direct.
// RULE_12: SRAM size defaults to 32K; may be set to 64K or 96K.
// RULE_13: Firmware must program the SRAM size after every reset.
// RULE_14: Writes from masters other than the CPU are always direct.
// RULE_15: Two flash memories work independently; one programs while the other reads.
// RULE_16: By default the primary flash sits at boot address; secondary disabled.
// RULE_17: Alternative boot places secondary flash at boot address; primary starts disabled.
// RULE_18: Boot choice is a non-volatile bit; only the test port may change it.
// RULE_19: Firmware should place the other flash just after the boot flash.
// RULE_20: The write FIFO forwards buffered writes in issue order.
module system_bus_map_write_buffer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Master request and answer
  input wire logic req_valid,
  input sys_map_pkg::bus_req_s req,
  output logic busy_q,
  output logic done_q,
  output logic err_q,
  output logic [31:0] rdata_q,
  // System bus toward the targets
  output logic sb_valid_q,
  output sys_map_pkg::sb_req_s sb_req_q,
  input wire logic sb_done,
  input wire logic [31:0] sb_rdata,
  // Flash program or erase activity, bit 0 primary, bit 1 secondary
  input wire logic [1:0] flash_prog_busy,
  // Non-volatile boot selection and its test-port programming path
  input wire logic nv_boot_sel,
  input wire logic tp_boot_wr,
  input wire logic tp_boot_val,
  output logic boot_sel_q,
  // Control register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_q
);
  import sys_map_pkg::*;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic buf_en_q, buf_en_d;
  logic [1:0] sram_sel_q, sram_sel_d;
  logic pri_en_q, pri_en_d, sec_en_q, sec_en_d;
  logic [25:0] pri_base_q, pri_base_d, sec_base_q, sec_base_d;
  logic boot_sel_d;
  logic [31:0] reg_rdata_d;

  bus_state_e state_q, state_d;
  logic pend_valid_q, pend_valid_d, pend_buf_q, pend_buf_d;
  sb_req_s pend_q, pend_d;
  logic busy_d, done_d, err_d;
  logic [31:0] rdata_d;
  logic sb_valid_d;
  sb_req_s sb_req_d;

  decode_s dec;
  logic [25:0] sram_limit;
  logic take, want_buf;
  sb_req_s new_req;

  logic push_valid, push_ready, pop_valid, pop_ready;
  sb_req_s push_data, pop_data;
  logic [`FIFO_CW-1:0] fifo_level;

  function automatic logic target_blocked(input target_e t, input logic [1:0] prog);
    // A flash being programmed blocks only its own traffic
    target_blocked = (t == TGT_FLASH_PRI && prog[0]) || (t == TGT_FLASH_SEC && prog[1]);
  endfunction

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  always_comb begin
    unique case (sram_sel_q)
      `SRAM_CODE_64K: sram_limit = `SRAM_SIZE_64K;
      `SRAM_CODE_96K: sram_limit = `SRAM_SIZE_96K;
      default: sram_limit = `SRAM_SIZE_32K; // see RULE_12
    endcase
  end

  always_comb begin
    dec.offset = req.addr[25:0]; // see RULE_01
    dec.buffered = 1'b0;
    dec.target = TGT_NONE;
    // Bit 28 splits each buffered window from its direct twin
    unique case (req.addr[31:26])
      `WIN_FLASH_BOOT, `WIN_BUF_FLASH, `WIN_DIR_FLASH: begin
        // Flash base and enable registers place each flash in the window
        if (pri_en_q && dec.offset >= pri_base_q &&
            (dec.offset - pri_base_q) < `PRI_FLASH_SIZE) begin
          dec.target = TGT_FLASH_PRI; // see RULE_02
        end else if (sec_en_q && dec.offset >= sec_base_q &&
                     (dec.offset - sec_base_q) < `SEC_FLASH_SIZE) begin
          dec.target = TGT_FLASH_SEC;
        end
      end
      `WIN_TCM_SRAM, `WIN_BUF_SRAM, `WIN_DIR_SRAM: begin
        if (dec.offset < sram_limit) begin
          dec.target = TGT_SRAM; // see RULE_11
        end
      end
      `WIN_EXT_CS0: dec.target = TGT_EXT_CS0;
      `WIN_BUF_BRIDGE0, `WIN_DIR_BRIDGE0: dec.target = TGT_BRIDGE0; // see RULE_10
      `WIN_BUF_BRIDGE1, `WIN_DIR_BRIDGE1: dec.target = TGT_BRIDGE1; // see RULE_10
      `WIN_BUF_USB, `WIN_DIR_USB: dec.target = TGT_USB;
      `WIN_BUF_EXTMEM, `WIN_DIR_EXTMEM: dec.target = TGT_EXTMEM;
      `WIN_BUF_DMA, `WIN_DIR_DMA: dec.target = TGT_DMA;
      `WIN_BUF_ENET, `WIN_DIR_ENET: dec.target = TGT_ENET;
      default: dec.target = TGT_NONE;
    endcase
    unique case (req.addr[31:26])
      `WIN_BUF_SRAM, `WIN_BUF_FLASH, `WIN_BUF_BRIDGE0, `WIN_BUF_BRIDGE1,
      `WIN_BUF_USB, `WIN_BUF_EXTMEM, `WIN_BUF_DMA, `WIN_BUF_ENET: begin
        dec.buffered = 1'b1; // see RULE_05
      end
      default: dec.buffered = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------------
  // Write FIFO
  // --------------------------------------------------------------------------
  write_fifo u_write_fifo (
    .sys_clk(sys_clk),
    .srst(srst),
    .push_valid(push_valid),
    .push_data(push_data),
    .push_ready(push_ready),
    .pop_valid(pop_valid),
    .pop_data(pop_data),
    .pop_ready(pop_ready),
    .level(fifo_level)
  );

  // --------------------------------------------------------------------------
  // Request path and system bus sequencer
  // --------------------------------------------------------------------------
  always_comb begin
    take = req_valid && !busy_q;
    new_req.target = dec.target;
    new_req.write = req.write;
    new_req.offset = dec.offset;
    new_req.wdata = req.wdata;
    // Only a CPU write, with buffering on, to a buffered alias is buffered
    want_buf = req.cpu && req.write && buf_en_q && dec.buffered; // see RULE_03 RULE_14
    push_valid = (take && want_buf && dec.target != TGT_NONE) ||
                 (pend_valid_q && pend_buf_q);
    push_data = pend_valid_q ? pend_q : new_req;
    pop_ready = 1'b0;

    state_d = state_q;
    pend_valid_d = pend_valid_q;
    pend_buf_d = pend_buf_q;
    pend_d = pend_q;
    busy_d = busy_q;
    done_d = 1'b0;
    err_d = 1'b0;
    rdata_d = rdata_q;
    sb_valid_d = sb_valid_q;
    sb_req_d = sb_req_q;

    if (take) begin
      if (dec.target == TGT_NONE) begin
        done_d = 1'b1;
        err_d = 1'b1;
        rdata_d = '0;
      end else if (want_buf && push_ready) begin
        done_d = 1'b1; // see RULE_06
        rdata_d = '0;
      end else begin
        // Full FIFO or direct access: hold the master
        pend_valid_d = 1'b1;
        pend_buf_d = want_buf; // see RULE_07 RULE_08 RULE_09
        pend_d = new_req;
        busy_d = 1'b1;
      end
    end

    if (pend_valid_q && pend_buf_q && push_ready) begin
      pend_valid_d = 1'b0; // see RULE_07
      busy_d = 1'b0;
      done_d = 1'b1;
      rdata_d = '0;
    end

    unique case (state_q)
      ST_IDLE: begin
        if (pop_valid && !target_blocked(pop_data.target, flash_prog_busy)) begin
          pop_ready = 1'b1; // see RULE_20
          sb_valid_d = 1'b1;
          sb_req_d = pop_data;
          state_d = ST_FIFO;
        end else if (!pop_valid && pend_valid_q && !pend_buf_q &&
                     !target_blocked(pend_q.target, flash_prog_busy)) begin
          // Direct traffic waits for earlier buffered writes to land
          sb_valid_d = 1'b1; // see RULE_08 RULE_09 RULE_15
          sb_req_d = pend_q;
          state_d = ST_DIRECT;
        end
      end
      ST_FIFO: begin
        if (sb_done) begin
          sb_valid_d = 1'b0;
          state_d = ST_IDLE;
        end
      end
      ST_DIRECT: begin
        if (sb_done) begin
          sb_valid_d = 1'b0;
          state_d = ST_IDLE;
          pend_valid_d = 1'b0;
          busy_d = 1'b0; // see RULE_08
          done_d = 1'b1;
          rdata_d = sb_req_q.write ? 32'h0000_0000 : sb_rdata;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
      pend_valid_q <= 1'b0;
      pend_buf_q <= 1'b0;
      pend_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= '0;
      sb_valid_q <= 1'b0;
      sb_req_q <= '0;
    end else begin
      state_q <= state_d;
      pend_valid_q <= pend_valid_d;
      pend_buf_q <= pend_buf_d;
      pend_q <= pend_d;
      busy_q <= busy_d;
      done_q <= done_d;
      err_q <= err_d;
      rdata_q <= rdata_d;
      sb_valid_q <= sb_valid_d;
      sb_req_q <= sb_req_d;
    end
  end

  // --------------------------------------------------------------------------
  // Control registers and boot selection
  // --------------------------------------------------------------------------
  always_comb begin
    buf_en_d = buf_en_q;
    sram_sel_d = sram_sel_q;
    pri_en_d = pri_en_q;
    sec_en_d = sec_en_q;
    pri_base_d = pri_base_q;
    sec_base_d = sec_base_q;
    // CPU writes never reach this bit
    boot_sel_d = tp_boot_wr ? tp_boot_val : boot_sel_q; // see RULE_18
    reg_rdata_d = '0;
    if (reg_wr) begin
      unique case (reg_addr)
        `REG_CTRL: begin
          buf_en_d = reg_wdata[`CTRL_BUF_EN];
          // Codes beyond the largest SRAM of this variant are ignored
          if (reg_wdata[`CTRL_SRAM_HI:`CTRL_SRAM_LO] <= `SRAM_CODE_MAX) begin
            sram_sel_d = reg_wdata[`CTRL_SRAM_HI:`CTRL_SRAM_LO]; // see RULE_12 RULE_13
          end
          pri_en_d = reg_wdata[`CTRL_PRI_EN];
          sec_en_d = reg_wdata[`CTRL_SEC_EN];
        end
        `REG_PRI_BASE: pri_base_d = reg_wdata[25:0]; // see RULE_19
        `REG_SEC_BASE: sec_base_d = reg_wdata[25:0]; // see RULE_19
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `REG_CTRL: begin
          reg_rdata_d[`CTRL_SRAM_HI:`CTRL_SRAM_LO] = sram_sel_q;
          reg_rdata_d[`CTRL_BUF_EN] = buf_en_q;
          reg_rdata_d[`CTRL_PRI_EN] = pri_en_q;
          reg_rdata_d[`CTRL_SEC_EN] = sec_en_q;
        end
        `REG_PRI_BASE: reg_rdata_d[25:0] = pri_base_q;
        `REG_SEC_BASE: reg_rdata_d[25:0] = sec_base_q;
        `REG_STATUS: begin
          reg_rdata_d[`STAT_LEVEL_HI:`STAT_LEVEL_LO] = fifo_level;
          reg_rdata_d[`STAT_FULL] = !push_ready;
          reg_rdata_d[`STAT_EMPTY] = !pop_valid;
          reg_rdata_d[`STAT_BOOT_SEL] = boot_sel_q;
          reg_rdata_d[`STAT_BUSY] = busy_q;
        end
        default: reg_rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      buf_en_q <= 1'b0; // see RULE_03
      sram_sel_q <= `SRAM_CODE_32K; // see RULE_12
      // Boot flash sits at offset zero, the other one starts disabled
      pri_en_q <= !nv_boot_sel; // see RULE_16 RULE_17
      sec_en_q <= nv_boot_sel; // see RULE_16 RULE_17
      pri_base_q <= 26'(`BOOT_ADDR); // see RULE_02
      sec_base_q <= 26'h0;
      boot_sel_q <= nv_boot_sel; // see RULE_18
      reg_rdata_q <= '0;
    end else begin
      buf_en_q <= buf_en_d;
      sram_sel_q <= sram_sel_d;
      pri_en_q <= pri_en_d;
      sec_en_q <= sec_en_d;
      pri_base_q <= pri_base_d;
      sec_base_q <= sec_base_d;
      boot_sel_q <= boot_sel_d;
      reg_rdata_q <= reg_rdata_d;
    end
  end

endmodule

// ### sys_map_properties.sv
// Concurrent checks on the ports of the system bus router
`timescale 1ns/1ps
module sys_map_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Master side
  input wire logic req_valid,
  input sys_map_pkg::bus_req_s req,
  input wire logic busy_q,
  input wire logic done_q,
  input wire logic err_q,
  input wire logic [31:0] rdata_q,
  // System bus
  input wire logic sb_valid_q,
  input sys_map_pkg::sb_req_s sb_req_q,
  input wire logic sb_done,
  input wire logic [31:0] sb_rdata,
  // Boot selection
  input wire logic tp_boot_wr,
  input wire logic tp_boot_val,
  input wire logic boot_sel_q
);
  import sys_map_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // ------
  // Sequences
  // ------
  // Only the first 32K of the direct SRAM alias, which every size setting maps
  sequence s_dir_sram;
    req_valid && !busy_q && req.addr[31:26] == 6'h14 && req.addr[25:15] == 11'h000;
  endsequence
  sequence s_wait_done;
    busy_q ##[0:300] (done_q && !busy_q);
  endsequence
  property p_busy_done;
    $fell(busy_q) |-> done_q;
  endproperty
  property p_err_done;
    err_q |-> done_q;
  endproperty
  property p_sb_drop;
    sb_valid_q && sb_done |=> !sb_valid_q;
  endproperty
  property p_sb_stable;
    sb_valid_q && !sb_done |=> sb_valid_q && $stable(sb_req_q);
  endproperty
  property p_read_direct;
    s_dir_sram ##0 !req.write |=> busy_q;
  endproperty
  property p_direct_write;
    s_dir_sram ##0 req.write |=> s_wait_done;
  endproperty
  property p_other_master;
    req_valid && !busy_q && req.write && !req.cpu && req.addr[31:26] == 6'h10 |=> busy_q;
  endproperty
  property p_read_data;
    sb_valid_q && sb_done && !sb_req_q.write |=> done_q && rdata_q == $past(sb_rdata);
  endproperty
  property p_boot_port;
    tp_boot_wr |=> boot_sel_q == $past(tp_boot_val);
  endproperty
  a_busy_done: assert property (p_busy_done) else $error("busy fell without done");
  a_err_done: assert property (p_err_done) else $error("error without done");
  a_sb_drop: assert property (p_sb_drop) else $error("bus valid held");
  a_sb_stable: assert property (p_sb_stable) else $error("bus request moved");
  a_read_direct: assert property (p_read_direct) else $error("read not held");
  a_direct_write: assert property (p_direct_write) else $error("direct write");
  a_other_master: assert property (p_other_master) else $error("other master");
  a_read_data: assert property (p_read_data) else $error("read data lost");
  a_boot_port: assert property (p_boot_port) else $error("boot bit not set");
endmodule

// ### sb_target_model.sv
// Behavioural system bus target answering after a set delay
`timescale 1ns/1ps
module sb_target_model (
  // Clock
  input wire logic sys_clk,
  // System bus
  input wire logic sb_valid,
  input sys_map_pkg::sb_req_s sb_req,
  output logic sb_done,
  output logic [31:0] sb_rdata,
  // Test control
  input wire logic stall,
  input wire logic [3:0] lat
);
  import sys_map_pkg::*;
  logic [3:0] wait_q;
  logic [31:0] last_q;
  assign sb_done = sb_valid && !stall && wait_q >= lat;
  // Data outside a completion are inverted so a stale value never passes
  assign sb_rdata = sb_done ? {6'h00, sb_req.offset} ^ 32'ha500_0000 : ~last_q;
  always_ff @(posedge sys_clk) begin
    wait_q <= (sb_valid && !sb_done) ? wait_q + 4'h1 : 4'h0;
    last_q <= sb_rdata;
  end
endmodule

// ### system_bus_map_write_buffer_tb.sv
// Self-checking testbench of the system bus router
`timescale 1ns/1ps
module system_bus_map_write_buffer_tb;
  import sys_map_pkg::*;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic req_valid = 1'b0;
  bus_req_s req = '0;
  logic busy_q, done_q, err_q, sb_valid_q, sb_done, boot_sel_q, er;
  logic [31:0] rdata_q, sb_rdata, reg_rdata_q, rd;
  sb_req_s sb_req_q, last_sb;
  logic [1:0] flash_prog_busy = 2'h0;
  logic nv_boot_sel = 1'b0, tp_boot_wr = 1'b0, tp_boot_val = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, stall = 1'b0;
  logic [3:0] lat = 4'h0;
  logic [31:0] wq[$];
  int num_errors = 0, comparisons = 0, busy_cnt = 0, n;
  logic [31:0] map_a [13] = '{32'h0000_0000, 32'h0400_0030, 32'h5000_0010, 32'h4000_0020,
    32'h3c00_0040, 32'h5800_1234, 32'h5c00_2008, 32'h7000_0100, 32'h7400_0004,
    32'h7800_0008, 32'h7c00_000c, 32'h5400_0040, 32'h4800_0010};
  target_e map_t [13] = '{TGT_FLASH_PRI, TGT_SRAM, TGT_SRAM, TGT_SRAM, TGT_EXT_CS0,
    TGT_BRIDGE0, TGT_BRIDGE1, TGT_USB, TGT_EXTMEM, TGT_DMA, TGT_ENET, TGT_FLASH_PRI, TGT_BRIDGE0};
  system_bus_map_write_buffer i_dut (.sys_clk, .srst, .req_valid, .req, .busy_q, .done_q,
    .err_q, .rdata_q, .sb_valid_q, .sb_req_q, .sb_done, .sb_rdata, .flash_prog_busy,
    .nv_boot_sel, .tp_boot_wr, .tp_boot_val, .boot_sel_q, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata_q);
  sb_target_model i_tgt (.sys_clk, .sb_valid(sb_valid_q), .sb_req(sb_req_q), .sb_done,
    .sb_rdata, .stall, .lat);
  initial forever #5 sys_clk = ~sys_clk;
  // Completed bus transfers, as the target saw them
  always @(posedge sys_clk) begin
    if (busy_q === 1'b1) busy_cnt++;
    if (sb_valid_q === 1'b1 && sb_done === 1'b1) begin
      last_sb = sb_req_q;
      if (sb_req_q.write) wq.push_back(sb_req_q.wdata);
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    $display("comparisons=%0d errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task end_test(input string s);
    $display("test %s done", s);
  endtask
  task do_reset;
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    #1;
  endtask
  // One request, held a cycle, then a bounded wait for its answer
  task access(input logic w, input logic c, input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req <= '{write: w, cpu: c, addr: a, wdata: d};
    @(posedge sys_clk);
    req_valid <= 1'b0;
    #1;
    n = 0;
    while (done_q !== 1'b1 && n < 300) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check({31'h0, n == 300}, 32'h0);
    rd = rdata_q;
    er = err_q;
  endtask
  task read_at(input logic [31:0] a, input target_e t);
    access(1'b0, 1'b1, a, 32'h0);
    check({28'h0, last_sb.target}, {28'h0, t});
    check({6'h0, last_sb.offset}, {6'h0, a[25:0]});
    check(rd, {6'h0, a[25:0]} ^ 32'ha500_0000);
  endtask
  task reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task reg_read(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata_q, exp);
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk);
    num_errors++;
    report_and_stop();
  end
  initial begin
    do_reset();
    check({31'h0, boot_sel_q}, 32'h0);
    reg_read(8'h00, 32'h0000_0100);
    reg_read(8'h0c, 32'h0000_0020);
    reg_read(8'h40, 32'h0);
    end_test("reset");
    for (int i = 0; i < 13; i++) begin
      lat <= i[0] ? 4'h2 : 4'h0;
      read_at(map_a[i], map_t[i]);
    end
    access(1'b0, 1'b1, 32'h8000_0000, 32'h0);
    check({31'h0, er}, 32'h1);
    end_test("map");
    access(1'b0, 1'b1, 32'h5000_9000, 32'h0);
    check({31'h0, er}, 32'h1);
    reg_write(8'h00, 32'h0000_0101);
    access(1'b0, 1'b1, 32'h5000_9000, 32'h0);
    check({31'h0, er}, 32'h0);
    reg_write(8'h00, 32'h0000_0102);
    reg_read(8'h00, 32'h0000_0102);
    access(1'b0, 1'b1, 32'h5001_8000, 32'h0);
    check({31'h0, er}, 32'h1);
    end_test("size");
    access(1'b1, 1'b1, 32'h4000_0100, 32'h11);
    check({31'h0, n == 0}, 32'h0);
    reg_write(8'h00, 32'h0000_0108);
    access(1'b1, 1'b1, 32'h4000_0104, 32'h12);
    check({31'h0, n == 0}, 32'h1);
    access(1'b1, 1'b0, 32'h4000_0108, 32'h13);
    check({31'h0, n == 0}, 32'h0);
    access(1'b1, 1'b1, 32'h5000_010c, 32'h14);
    check({31'h0, n == 0}, 32'h0);
    end_test("buffering");
    // Target stalls so the fifo fills and the last write must wait
    stall <= 1'b1;
    wq.delete();
    busy_cnt = 0;
    fork
      begin
        repeat (40) @(posedge sys_clk);
        stall <= 1'b0;
      end
    join_none
    for (int i = 0; i < 6; i++) access(1'b1, 1'b1, 32'h4000_0200 + i * 4, 32'(i + 1));
    check({31'h0, busy_cnt > 0}, 32'h1);
    access(1'b0, 1'b1, 32'h5000_0000, 32'h0);
    check({31'h0, last_sb.write}, 32'h0);
    check(32'(wq.size()), 32'h6);
    for (int i = 0; i < 6; i++) check(wq[i], 32'(i + 1));
    end_test("fifo");
    flash_prog_busy <= 2'b10;
    read_at(32'h0000_0000, TGT_FLASH_PRI);
    flash_prog_busy <= 2'b00;
    end_test("flash");
    // Secondary flash is off until firmware enables and places it
    access(1'b0, 1'b1, 32'h0008_0000, 32'h0);
    check({31'h0, er}, 32'h1);
    reg_write(8'h00, 32'h0000_0300);
    reg_write(8'h08, 32'h0008_0000);
    read_at(32'h0008_0000, TGT_FLASH_SEC);
    read_at(32'h0000_0004, TGT_FLASH_PRI);
    end_test("place");
    @(posedge sys_clk);
    tp_boot_wr <= 1'b1;
    tp_boot_val <= 1'b1;
    @(posedge sys_clk);
    tp_boot_wr <= 1'b0;
    #1;
    check({31'h0, boot_sel_q}, 32'h1);
    reg_write(8'h0c, 32'h0);
    reg_read(8'h0c, 32'h0000_0120);
    nv_boot_sel <= 1'b1;
    do_reset();
    check({31'h0, boot_sel_q}, 32'h1);
    reg_read(8'h00, 32'h0000_0200);
    read_at(32'h0000_0000, TGT_FLASH_SEC);
    end_test("boot");
    report_and_stop();
  end
endmodule
bind system_bus_map_write_buffer sys_map_checker i_chk (.sys_clk, .srst, .req_valid, .req,
  .busy_q, .done_q, .err_q, .rdata_q, .sb_valid_q, .sb_req_q, .sb_done, .sb_rdata,
  .tp_boot_wr, .tp_boot_val, .boot_sel_q);
